// file: inc/lsrc_pkg.sv
// Constants, types and helpers shared by the light sensor result and configuration logic.
// Assumes a single 100 MHz reference clock and a register front end that is already decoded.
//
// Contract
// - Result equals mantissa times 0.01 lux times 2^exponent.
// - Codes 0..11 double full scale, 40.95 to 83865.60.
// - Low twelve bits hold unsigned straight binary magnitude.
// - Mask set with manual range reports exponent zero.
// - Configuration write aborts a running conversion at once.
// - New settings needing conversion start a fresh one.
// - Configuration field layout; bits 8:7 are read-only flags, bits 6:5 read zero.
// - Configuration at offset one resets to C810h.
// - Range 1100b selects automatic range, reported as exponent.
// - Manual range code uses the result exponent encoding.
// - Time bit zero 100 ms, one 800 ms.
// - Short time drops low bits up to 0101b.
// - Result layout and weight independent of conversion time.
// - Mode: 00 shutdown, 01 single, 10/11 continuous.
// - Single shot reads 01 while converting, then clears.
// - Overrange flag re-evaluated on every measurement.
// - Auto overrange below maximum steps up and restarts.
package lsrc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RESULT_ADDR = 8'h00;
  localparam logic [7:0] CONFIG_ADDR = 8'h01;
  localparam logic [15:0] CONFIG_RESET = 16'hC810;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EXP_LSB = 12;
  localparam int RANGE_LSB = 12;
  localparam int TIME_BIT = 11;
  localparam int MODE_LSB = 9;
  localparam int OVF_BIT = 8;
  localparam int DONE_BIT = 7;
  localparam int MASK_BIT = 2;
  localparam int HOST_LOW_MSB = 4;

  // ----------------------------------------------------------------
  // Codes and limits
  // ----------------------------------------------------------------
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [3:0] RANGE_MAX = 4'hB;
  localparam logic [3:0] RANGE_MIN = 4'h0;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [11:0] MANT_MAX = 12'hFFF;
  localparam int MANT_WIDTH = 12;
  // Light level arrives in hundredths of a lux, the weight of one count at exponent zero.
  localparam int LEVEL_WIDTH = 23;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int SHORT_TIME_MS = 100;
  localparam int LONG_TIME_MS = 800;
  localparam int SHORT_CYCLES = SHORT_TIME_MS * (REF_CLK_HZ / 1000);
  localparam int LONG_CYCLES = LONG_TIME_MS * (REF_CLK_HZ / 1000);
  localparam int TIMER_WIDTH = 27;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [15:0] wrData;
  } lsrc_reg_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_INTEG = 2'b10
  } lsrc_state_type;

  // Bits of effective resolution lost with the short conversion time.
  function automatic logic [1:0] resolution_loss(input logic [3:0] exponent);
    if (exponent == 4'h0) begin
      return 2'h3;
    end else if (exponent <= 4'h4) begin
      return 2'h2;
    end else if (exponent == 4'h5) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

endpackage

// file: logic/lsrc_formatter.sv
// Turns a light level into mantissa, fit flag and best automatic range.
// Assumes the level is in hundredths of a lux and stable while it is read.
module lsrc_formatter #(
  parameter int LEVEL_WIDTH = lsrc_pkg::LEVEL_WIDTH
) (
  // Measurement
  input wire logic [LEVEL_WIDTH-1:0] level,
  input wire logic [3:0] exponent,
  input wire logic shortTime,
  // Formatted view
  output logic [11:0] mantissa,
  output logic fits,
  output logic [3:0] bestExp
);

  if (LEVEL_WIDTH <= lsrc_pkg::MANT_WIDTH || LEVEL_WIDTH > 24) begin : g_check
    $error("lsrc_formatter: LEVEL_WIDTH must lie between 13 and 24");
  end

  // ----------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------
  function automatic logic fits_in(input logic [LEVEL_WIDTH-1:0] lvl, input logic [3:0] e);
    logic [LEVEL_WIDTH-1:0] s;
    s = lvl >> e;
    return s[LEVEL_WIDTH-1:lsrc_pkg::MANT_WIDTH] == '0;
  endfunction

  localparam logic [11:0] MANT_MAX_MASK = 12'hFFF;
  logic [LEVEL_WIDTH-1:0] scaled;
  logic [11:0] lowMask;

  always_comb begin
    scaled = level >> exponent;
    fits = fits_in(level, exponent);
    // The loss mask depends only on the range and the time bit, so the weight per count stays put.
    lowMask = shortTime ? (MANT_MAX_MASK << lsrc_pkg::resolution_loss(exponent)) : 12'hFFF;
    mantissa = (fits ? scaled[11:0] : lsrc_pkg::MANT_MAX) & lowMask;
  end

  always_comb begin
    bestExp = lsrc_pkg::RANGE_MAX;
    for (int e = 11; e >= 0; e--) begin
      if (fits_in(level, 4'(e))) begin
        bestExp = 4'(e);
      end
    end
  end

endmodule

// file: logic/lsrc_light_sensor.sv
// Measurement control, result register and configuration register of the light sensor.
// Assumes a serial front end that presents decoded register requests on ref_clk,
// and an integrating converter on the same clock that reports the level and overloads.
module lsrc_light_sensor #(
  parameter int SHORT_CYCLES = lsrc_pkg::SHORT_CYCLES,
  parameter int LONG_CYCLES = lsrc_pkg::LONG_CYCLES,
  parameter int LEVEL_WIDTH = lsrc_pkg::LEVEL_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register requests from the serial front end
  input wire lsrc_pkg::lsrc_reg_req_type regReq,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Integrating converter
  input wire logic [LEVEL_WIDTH-1:0] lightLevel,
  input wire logic overloadSpike,
  output logic integrating,
  output logic integrationLong,
  output logic integratorClear,
  output logic [3:0] activeRangeOut
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int TW = lsrc_pkg::TIMER_WIDTH;

  if (SHORT_CYCLES < 1 || LONG_CYCLES < 1) begin : g_time_check
    $error("lsrc_light_sensor: conversion times must be at least one cycle");
  end
  if (SHORT_CYCLES > (1 << TW) || LONG_CYCLES > (1 << TW)) begin : g_width_check
    $error("lsrc_light_sensor: conversion time exceeds the timer width");
  end

  localparam logic [TW-1:0] SHORT_LOAD = TW'(SHORT_CYCLES - 1);
  localparam logic [TW-1:0] LONG_LOAD = TW'(LONG_CYCLES - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lsrc_pkg::lsrc_state_type state_q;
  logic [3:0] rangeSel_q;
  logic longTime_q;
  logic [1:0] mode_q;
  logic [4:0] hostLow_q;
  logic ovf_q;
  logic done_q;
  logic [15:0] result_q;
  logic [TW-1:0] timer_q;
  logic [3:0] autoRange_q;
  logic spikeSeen_q;
  logic upranged_q;
  logic [15:0] rdData_q;
  logic rdValid_q;
  logic clear_q;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic cfgWrite;
  logic cfgRead;
  logic [3:0] newRange;
  logic newLong;
  logic [1:0] newMode;
  logic newConv;

  always_comb begin
    cfgWrite = regReq.write && (regReq.addr == lsrc_pkg::CONFIG_ADDR);
    cfgRead = regReq.read && (regReq.addr == lsrc_pkg::CONFIG_ADDR);
    newRange = regReq.wrData[lsrc_pkg::RANGE_LSB +: 4];
    newLong = regReq.wrData[lsrc_pkg::TIME_BIT];
    newMode = regReq.wrData[lsrc_pkg::MODE_LSB +: 2];
    newConv = newMode != lsrc_pkg::MODE_SHUTDOWN;
  end

  // ----------------------------------------------------------------
  // Range in use
  // ----------------------------------------------------------------
  // Reserved codes above the automatic code fall back to automatic ranging,
  // so a stray value still yields a meaningful exponent.
  logic autoMode;
  logic [3:0] activeRange;
  logic maskExp;

  always_comb begin
    autoMode = rangeSel_q >= lsrc_pkg::RANGE_AUTO;
    activeRange = autoMode ? autoRange_q : rangeSel_q;
    maskExp = hostLow_q[lsrc_pkg::MASK_BIT] && !autoMode;
  end

  // ----------------------------------------------------------------
  // Formatting
  // ----------------------------------------------------------------
  logic [11:0] mantissa;
  logic fits;
  logic [3:0] bestExp;

  lsrc_formatter #(
    .LEVEL_WIDTH(LEVEL_WIDTH)
  ) u_formatter (
    .level(lightLevel),
    .exponent(activeRange),
    .shortTime(!longTime_q),
    .mantissa(mantissa),
    .fits(fits),
    .bestExp(bestExp)
  );

  // ----------------------------------------------------------------
  // Conversion events
  // ----------------------------------------------------------------
  logic timerDone;
  logic autoUp;
  logic measDone;
  logic loadTimer;
  logic loadLong;

  always_comb begin
    timerDone = (state_q == lsrc_pkg::ST_INTEG) && (timer_q == '0);
    // An overload in automatic mode below the top range aborts and steps up.
    autoUp = (state_q == lsrc_pkg::ST_INTEG) && !cfgWrite && autoMode
      && (autoRange_q < lsrc_pkg::RANGE_MAX)
      && (overloadSpike || (timerDone && !fits));
    measDone = timerDone && !cfgWrite && !autoUp;
    loadTimer = (cfgWrite && newConv) || autoUp
      || (measDone && (mode_q != lsrc_pkg::MODE_SINGLE));
    loadLong = cfgWrite ? newLong : longTime_q;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= lsrc_pkg::ST_IDLE;
    end else begin
      case (state_q)
        lsrc_pkg::ST_IDLE: begin
          if (cfgWrite && newConv) begin
            state_q <= lsrc_pkg::ST_INTEG;
          end
        end
        lsrc_pkg::ST_INTEG: begin
          if (cfgWrite) begin
            state_q <= newConv ? lsrc_pkg::ST_INTEG : lsrc_pkg::ST_IDLE;
          end else if (measDone && (mode_q == lsrc_pkg::MODE_SINGLE)) begin
            state_q <= lsrc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= lsrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timer_q <= '0;
    end else if (loadTimer) begin
      timer_q <= loadLong ? LONG_LOAD : SHORT_LOAD;
    end else if (state_q == lsrc_pkg::ST_INTEG && timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= loadTimer;
    end
  end

  // ----------------------------------------------------------------
  // Configuration fields written by the host
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rangeSel_q <= lsrc_pkg::CONFIG_RESET[lsrc_pkg::RANGE_LSB +: 4];
      longTime_q <= lsrc_pkg::CONFIG_RESET[lsrc_pkg::TIME_BIT];
      hostLow_q <= lsrc_pkg::CONFIG_RESET[lsrc_pkg::HOST_LOW_MSB:0];
    end else if (cfgWrite) begin
      rangeSel_q <= newRange;
      longTime_q <= newLong;
      hostLow_q <= regReq.wrData[lsrc_pkg::HOST_LOW_MSB:0];
    end
  end

  // Single shot clears itself only when the conversion really completes.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= lsrc_pkg::CONFIG_RESET[lsrc_pkg::MODE_LSB +: 2];
    end else if (cfgWrite) begin
      mode_q <= newMode;
    end else if (measDone && (mode_q == lsrc_pkg::MODE_SINGLE)) begin
      mode_q <= lsrc_pkg::MODE_SHUTDOWN;
    end
  end

  // ----------------------------------------------------------------
  // Automatic ranging
  // ----------------------------------------------------------------
  // After a clean result the next conversion starts in the best fitting range,
  // which lets the range also come down when the light drops.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      autoRange_q <= lsrc_pkg::RANGE_MIN;
    end else if (autoUp) begin
      autoRange_q <= autoRange_q + 4'h1;
    end else if (measDone && autoMode) begin
      autoRange_q <= bestExp;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      upranged_q <= 1'b0;
    end else if (cfgWrite || measDone) begin
      upranged_q <= 1'b0;
    end else if (autoUp) begin
      upranged_q <= 1'b1;
    end
  end

  // A short spike inside a manual conversion is remembered until the result.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      spikeSeen_q <= 1'b0;
    end else if (loadTimer) begin
      spikeSeen_q <= 1'b0;
    end else if (state_q == lsrc_pkg::ST_INTEG && overloadSpike) begin
      spikeSeen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result and status
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      result_q <= 16'h0000;
    end else if (measDone) begin
      result_q[lsrc_pkg::EXP_LSB +: 4] <= maskExp ? 4'h0 : activeRange;
      result_q[11:0] <= mantissa;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (measDone) begin
      ovf_q <= !fits || overloadSpike || spikeSeen_q || upranged_q;
    end
  end

  // Completion sets the ready flag; a read of the configuration clears it,
  // and a completion in the same cycle wins.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (measDone) begin
      done_q <= 1'b1;
    end else if (cfgRead) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [15:0] cfgView;

  always_comb begin
    cfgView = 16'h0000;
    cfgView[lsrc_pkg::RANGE_LSB +: 4] = rangeSel_q;
    cfgView[lsrc_pkg::TIME_BIT] = longTime_q;
    cfgView[lsrc_pkg::MODE_LSB +: 2] = mode_q;
    cfgView[lsrc_pkg::OVF_BIT] = ovf_q;
    cfgView[lsrc_pkg::DONE_BIT] = done_q;
    cfgView[lsrc_pkg::HOST_LOW_MSB:0] = hostLow_q;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdData_q <= 16'h0000;
    end else if (regReq.read) begin
      case (regReq.addr)
        lsrc_pkg::RESULT_ADDR: begin
          rdData_q <= result_q;
        end
        lsrc_pkg::CONFIG_ADDR: begin
          rdData_q <= cfgView;
        end
        default: begin
          rdData_q <= 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= regReq.read;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    regRdData = rdData_q;
    regRdValid = rdValid_q;
    integrating = state_q == lsrc_pkg::ST_INTEG;
    integrationLong = longTime_q;
    integratorClear = clear_q;
    activeRangeOut = activeRange;
  end

endmodule

// file: tb/lsrc_host_model.sv
// Register host model that issues word-wide requests on ref_clk.
// Assumes the bench calls its tasks from one process at a time.
module lsrc_host_model (
  // Clock
  input wire logic ref_clk,
  // Register requests and answers
  output lsrc_pkg::lsrc_reg_req_type regReq,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  initial regReq = '0;

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    // Reserved range codes are never sent; they fold to automatic.
    if (addr == lsrc_pkg::CONFIG_ADDR && d[15:12] > 4'hc) d[15:12] = 4'hc;
    @(posedge ref_clk);
    regReq <= '{write: 1'b1, read: 1'b0, addr: addr, wrData: d};
    @(posedge ref_clk);
    regReq.write <= 1'b0;
    // Stale data is inverted so a design that samples it outside a write shows up.
    regReq.wrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic valid);
    @(posedge ref_clk);
    regReq.read <= 1'b1;
    regReq.addr <= addr;
    @(posedge ref_clk);
    regReq.read <= 1'b0;
    #1;
    valid = regRdValid;
    data = regRdData;
  endtask
endmodule

// file: tb/lsrc_light_sensor_assertions.sv
// Concurrent checks on the light sensor top-level ports.
// Assumes it is bound to every lsrc_light_sensor instance.
module lsrc_light_sensor_assertions #(
  parameter int SHORT_CYCLES = 8,
  parameter int LONG_CYCLES = 20,
  parameter int LEVEL_WIDTH = 23
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register side
  input wire lsrc_pkg::lsrc_reg_req_type regReq,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  // Converter side
  input wire logic [LEVEL_WIDTH-1:0] lightLevel,
  input wire logic overloadSpike,
  input wire logic integrating,
  input wire logic integrationLong,
  input wire logic integratorClear,
  input wire logic [3:0] activeRangeOut
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic cfgWr;
  assign cfgWr = regReq.write && regReq.addr == lsrc_pkg::CONFIG_ADDR;
  sequence convStart;
    integratorClear && integrating;
  endsequence
  sequence shortStart;
    integratorClear && !integrationLong;
  endsequence
  sequence quietSpan;
    (!regReq.write && !overloadSpike) [*6];
  endsequence
  readAnswer_a: assert property (regRdValid == $past(regReq.read))
    else $error("read answer strobe wrong");
  unmappedRead_a: assert property (regReq.read && regReq.addr > 8'h01
    |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  writeAborts_a: assert property (cfgWr && regReq.wrData[10:9] == 2'b00 |=> !integrating)
    else $error("conversion not aborted");
  writeStarts_a: assert property (cfgWr && regReq.wrData[10:9] != 2'b00 |=> convStart)
    else $error("conversion not started");
  timeBit_a: assert property (cfgWr |=> integrationLong == $past(regReq.wrData[11]))
    else $error("time bit not applied");
  manualRange_a: assert property (cfgWr && regReq.wrData[15:12] < 4'hc
    |=> activeRangeOut == $past(regReq.wrData[15:12]))
    else $error("manual range not applied");
  shortHold_a: assert property (shortStart ##1 quietSpan |-> integrating)
    else $error("short conversion ended early");
  pulseOnce_a: assert property (integratorClear |=> !integratorClear)
    else $error("clear pulse too long");
  idleRange_a: assert property (!integrating && !regReq.write |=> $stable(activeRangeOut))
    else $error("range moved while idle");
endmodule

bind lsrc_light_sensor lsrc_light_sensor_assertions #(.SHORT_CYCLES(SHORT_CYCLES),
  .LONG_CYCLES(LONG_CYCLES), .LEVEL_WIDTH(LEVEL_WIDTH)) chk (.ref_clk(ref_clk),
  .reset(reset), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
  .lightLevel(lightLevel), .overloadSpike(overloadSpike), .integrating(integrating),
  .integrationLong(integrationLong), .integratorClear(integratorClear),
  .activeRangeOut(activeRangeOut));

// file: tb/test_light_sensor_result_and_config.sv
// Self-checking bench for the light sensor result and configuration logic.
// Assumes the host model and the bound checker are compiled with it.
module test_light_sensor_result_and_config;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  // Short counts keep the run brief; expectations derive from them.
  localparam int SHORT_N = 8;
  localparam int LONG_N = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [22:0] lightLevel = '0;
  logic overloadSpike = 1'b0;
  lsrc_pkg::lsrc_reg_req_type regReq;
  logic [15:0] regRdData;
  logic regRdValid, integrating, integrationLong, integratorClear;
  logic [3:0] activeRangeOut;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_b0ed;

  lsrc_light_sensor #(.SHORT_CYCLES(SHORT_N), .LONG_CYCLES(LONG_N), .LEVEL_WIDTH(23)) DUT (
    .ref_clk(ref_clk), .reset(reset), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .lightLevel(lightLevel), .overloadSpike(overloadSpike),
    .integrating(integrating), .integrationLong(integrationLong),
    .integratorClear(integratorClear), .activeRangeOut(activeRangeOut));
  lsrc_host_model host (.ref_clk(ref_clk), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid));

  initial forever #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] mant(input logic [3:0] e, input logic ct, input logic [22:0] lv);
    logic [22:0] m;
    int k;
    m = lv >> e;
    if (m > 23'h00_0fff) m = 23'h00_0fff;
    k = ct ? 0 : (e == 4'h0) ? 3 : (e <= 4'h4) ? 2 : (e == 4'h5) ? 1 : 0;
    return 12'((m >> k) << k);
  endfunction

  task automatic end_of_test();
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.rd(a, d, v);
    chkBit(v, 1'b1);
    chkWord(d, exp);
  endtask

  // Returns the number of cycles the conversion kept integrating high.
  task automatic measure(input logic [15:0] cfg, input logic [22:0] lv, input logic sp,
                         output int n);
    @(posedge ref_clk);
    lightLevel <= lv;
    host.wr(8'h01, cfg);
    #1;
    n = 0;
    while (integrating === 1'b1 && n < 400) begin
      @(posedge ref_clk);
      overloadSpike <= sp && n == 2;
      #1;
      n++;
    end
  endtask

  task automatic waitClr(input int k);
    int t;
    t = 0;
    while (k > 0 && t < 200) begin
      @(posedge ref_clk);
      #1;
      if (integratorClear === 1'b1) k--;
      t++;
    end
    chkBit(1'(k == 0), 1'b1);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [3:0] r;
    logic ct, sp, ov;
    logic [4:0] lo;
    logic [22:0] lv;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chkBit(integrationLong, 1'b1);
    rdChk(8'h01, 16'hc810);
    host.wr(8'h00, 16'hffff);
    host.wr(8'h07, 16'hffff);
    rdChk(8'h00, 16'h0000);
    rdChk(8'h07, 16'h0000);
    host.wr(8'h01, 16'h31ff);
    rdChk(8'h01, 16'h301f);
    // Automatic range climbs from zero, then settles low again.
    measure(16'hc204, 23'h12_3456, 1'b0, n);
    rdChk(8'h00, {4'h9, mant(4'h9, 1'b0, 23'h12_3456)});
    rdChk(8'h01, 16'hc184);
    measure(16'hc204, 23'h00_0064, 1'b0, n);
    rdChk(8'h00, 16'h9000);
    rdChk(8'h01, 16'hc084);
    measure(16'hc204, 23'h00_0064, 1'b0, n);
    rdChk(8'h00, 16'h0060);
    // A spike in automatic mode aborts at once and restarts one range up.
    measure(16'hc204, 23'h00_0064, 1'b1, n);
    chkWord(16'(n), 16'(SHORT_N + 4));
    rdChk(8'h00, {4'h1, mant(4'h1, 1'b0, 23'h00_0064)});
    rdChk(8'h01, 16'hc184);
    ov = 1'b0;
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      r = seed[3:0] % 4'hc;
      ct = seed[4];
      lo = seed[9:5];
      sp = seed[10] & seed[11];
      lv = ({11'h000, seed[23:12]} << r) | (23'(seed[31:24]) & ((23'h00_0001 << r) - 1));
      if (i == 0) begin
        r = 4'h0;
        ct = 1'b1;
        lv = 23'h00_2000;
      end
      if (i == 1) begin
        r = 4'hb;
        ct = 1'b1;
        lv = 23'h7f_ffff;
      end
      ov = sp || (lv >> r) > 23'h00_0fff;
      measure({r, ct, 2'b01, 4'h0, lo}, lv, sp, n);
      chkWord(16'(n), ct ? 16'(LONG_N) : 16'(SHORT_N));
      rdChk(8'h00, {(lo[2] ? 4'h0 : r), mant(r, ct, lv)});
      rdChk(8'h01, {r, ct, 2'b00, ov, 1'b1, 2'b00, lo});
    end
    @(posedge ref_clk);
    lightLevel <= 23'h00_0123;
    host.wr(8'h01, 16'h3a00);
    rdChk(8'h01, 16'h3a00 | {7'h00, ov, 8'h00});
    host.wr(8'h01, 16'h3800);
    #1;
    chkBit(integrating, 1'b0);
    host.wr(8'h01, 16'h2400);
    waitClr(3);
    host.wr(8'h01, 16'h2600);
    waitClr(3);
    chkBit(integrating, 1'b1);
    rdChk(8'h00, {4'h2, mant(4'h2, 1'b0, 23'h00_0123)});
    host.wr(8'h01, 16'h2000);
    #1;
    chkBit(integrating, 1'b0);
    // A reset after shutdown brings the configuration back to its power-up value.
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    rdChk(8'h01, 16'hc810);
    end_of_test();
  end
endmodule
